/* src/tmc_timer.sv */
// Sixteen-bit timer/counter with prescaler, oscillator control and AHB-Lite registers
`timescale 1ns/100ps
`include "tmc_regs.svh"

module tmc_timer
    import tmc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // External clock side
    input  wire logic        ext_clk_pin,
    input  wire logic        osc_in_pin,
    // System context
    input  wire logic        sleep_mode,
    input  wire logic        adc_enable,
    // Status and control outputs
    output logic             osc_run,
    output logic             osc_pins_force_input,
    output logic             overflow_irq,
    output logic             adc_start
);

    // Register state
    logic [7:0]  ctrl_r;
    logic [7:0]  flags_r;
    logic [7:0]  enables_r;
    logic [15:0] cmp_pair_r;
    logic [3:0]  cmp_mode_r;
    logic [15:0] count_r;
    logic [7:0]  hi_buf_r;
    logic [2:0]  presc_r;
    logic [1:0]  inst_div_r;
    logic        match_q_r;
    logic        adc_start_r;

    // Bus state
    tmc_bus_st_t bus_st_r;
    logic [11:0] addr_r;
    logic        wr_pend_r;
    logic [31:0] hrdata_r;

    // External input conditioning
    logic        sync1_r;
    logic        sync2_r;
    logic        sync3_r;
    logic        raw_q_r;

    // Decoded strobes and events
    logic        addr_ok;
    logic        wr_ctrl;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_flags;
    logic        wr_en;
    logic        wr_cmp;
    logic        wr_mode;
    logic        rd_lo;
    logic        atomic;
    logic        ext_src;
    logic        src_edge;
    logic        presc_done;
    logic        inc;
    logic        trig;
    logic        ovf_set;
    logic        inst_tick;
    logic        ext_level;

    // Last prescaler state for the selected ratio
    function automatic logic [2:0] presc_last(input logic [1:0] sel);
        case (sel)
            2'h0:    presc_last = 3'h0;
            2'h1:    presc_last = 3'h1;
            2'h2:    presc_last = 3'h3;
            default: presc_last = 3'h7;
        endcase
    endfunction

    // Register read view; bit 6 of control reads zero
    // Unmapped offsets read as zero after the same one wait state as other reads
    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        case (a)
            `TMC_OFF_CONTROL:  rd_mux = {24'h000000, ctrl_r & 8'hBF};
            `TMC_OFF_COUNT_LO: rd_mux = {24'h000000, count_r[7:0]};
            `TMC_OFF_COUNT_HI: rd_mux = {24'h000000,
                                         atomic ? hi_buf_r : count_r[15:8]};
            `TMC_OFF_FLAGS:    rd_mux = {24'h000000, flags_r};
            `TMC_OFF_ENABLES:  rd_mux = {24'h000000, enables_r};
            `TMC_OFF_CMP_PAIR: rd_mux = {16'h0000, cmp_pair_r};
            `TMC_OFF_CMP_MODE: rd_mux = {28'h0000000, cmp_mode_r};
            default:           rd_mux = 32'h00000000;
        endcase
    endfunction

    // Compare hit in the special event mode; shared by the trigger and its edge stage
    function automatic logic special_hit(input logic [3:0] mode, input logic [15:0] cnt,
                                         input logic [15:0] cmp);
        special_hit = (mode == `TMC_CMP_SPECIAL) && (cnt == cmp);
    endfunction

    // Bus outputs; reads take one wait state so side effects settle first
    // Writes need no wait: hwdata is taken at the end of the data phase
    assign hreadyout = (bus_st_r != TMC_BUS_RD_WAIT);
    assign hrdata    = hrdata_r;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    // Address phase capture and read sequencing
    // A new address phase is only taken while hready is high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r  <= TMC_BUS_IDLE;
            addr_r    <= 12'h000;
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            if (addr_ok) begin
                addr_r <= haddr[11:0];
            end
            if (bus_st_r == TMC_BUS_RD_WAIT) begin
                bus_st_r <= TMC_BUS_IDLE;
            end else if (addr_ok && !hwrite) begin
                bus_st_r <= TMC_BUS_RD_WAIT;
            end
        end
    end

    // Read data latched at the end of the wait state
    // Held until the next read, so a slow master still sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (bus_st_r == TMC_BUS_RD_WAIT) begin
            hrdata_r <= rd_mux(addr_r);
        end
    end

    // Write strobes in the data phase
    // Strobes use the registered address, so they stand only in the data phase
    assign wr_ctrl  = wr_pend_r && (addr_r == `TMC_OFF_CONTROL);
    assign wr_lo    = wr_pend_r && (addr_r == `TMC_OFF_COUNT_LO);
    assign wr_hi    = wr_pend_r && (addr_r == `TMC_OFF_COUNT_HI);
    assign wr_flags = wr_pend_r && (addr_r == `TMC_OFF_FLAGS);
    assign wr_en    = wr_pend_r && (addr_r == `TMC_OFF_ENABLES);
    assign wr_cmp   = wr_pend_r && (addr_r == `TMC_OFF_CMP_PAIR);
    assign wr_mode  = wr_pend_r && (addr_r == `TMC_OFF_CMP_MODE);
    assign rd_lo    = (bus_st_r == TMC_BUS_RD_WAIT) && (addr_r == `TMC_OFF_COUNT_LO);
    assign atomic   = ctrl_r[`TMC_BIT_ATOMIC];
    assign ext_src  = ctrl_r[`TMC_BIT_CLK_SRC];

    // Control, enable and compare registers; counter off after reset
    // Bit 6 masked on the way in too, so it can never be set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r     <= `TMC_RST_CONTROL;
            enables_r  <= `TMC_RST_ENABLES;
            cmp_pair_r <= `TMC_RST_CMP_PAIR;
            cmp_mode_r <= `TMC_RST_CMP_MODE;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= hwdata[7:0] & 8'hBF;
            end
            if (wr_en) begin
                enables_r <= hwdata[7:0];
            end
            if (wr_cmp) begin
                cmp_pair_r <= hwdata[15:0];
            end
            if (wr_mode) begin
                cmp_mode_r <= hwdata[3:0];
            end
        end
    end

    // Oscillator runs regardless of sleep and takes over both pins
    // Sleep leaves osc_run alone, so a crystal clocked count with the sync bypass set survives it
    assign osc_run              = ctrl_r[`TMC_BIT_OSC_EN];
    assign osc_pins_force_input = ctrl_r[`TMC_BIT_OSC_EN];

    // Instruction cycle divider; halts in sleep like the core clock
    // Free running, so the first tick after enable may come early
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inst_div_r <= 2'h0;
        end else if (!sleep_mode) begin
            inst_div_r <= inst_div_r + 2'h1;
        end
    end
    assign inst_tick = !sleep_mode && (inst_div_r == `TMC_INST_DIV);

    // External level: oscillator input when running, else clock pin
    // Switching source while both lines idle low makes no false edge
    assign ext_level = ctrl_r[`TMC_BIT_OSC_EN] ? osc_in_pin : ext_clk_pin;

    // Two-stage synchroniser plus edge stage; raw sample for bypass path
    // Sync path costs three core edges but is safe with trigger resets
    // Only sync2_r reads sync1_r; the bypass keeps its own sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            raw_q_r <= 1'b0;
        end else begin
            sync1_r <= ext_level;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            raw_q_r <= ext_level;
        end
    end

    // Source edge selection; synced edges depend on the core clock, so not in sleep
    // Bypass edges keep counting in sleep; sync edges wait for the core clock
    always_comb begin
        if (!ext_src) begin
            src_edge = inst_tick;
        end else if (ctrl_r[`TMC_BIT_SYNC_BYP]) begin
            src_edge = ext_level && !raw_q_r;
        end else begin
            src_edge = sync2_r && !sync3_r && !sleep_mode;
        end
    end

    // Prescaler; ratio picked by the two-bit field
    // Cleared by low byte writes so a fresh load waits a full ratio
    assign presc_done = (presc_r == presc_last(ctrl_r[`TMC_BIT_PRESC_HI:`TMC_BIT_PRESC_LO]));
    assign inc        = ctrl_r[`TMC_BIT_COUNT_EN] && src_edge && presc_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= 3'h0;
        end else if (wr_lo) begin
            presc_r <= 3'h0;
        end else if (ctrl_r[`TMC_BIT_COUNT_EN] && src_edge) begin
            presc_r <= presc_done ? 3'h0 : presc_r + 3'h1;
        end
    end

    // Special event trigger: one pulse per compare match in mode 1011
    // Edge stage stops a held match from clearing the count on every cycle
    assign trig = special_hit(cmp_mode_r, count_r, cmp_pair_r) && !match_q_r;

    // Match edge stage; conversion start one cycle after the trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_q_r   <= 1'b0;
            adc_start_r <= 1'b0;
        end else begin
            match_q_r   <= special_hit(cmp_mode_r, count_r, cmp_pair_r);
            adc_start_r <= trig && adc_enable;
        end
    end
    assign adc_start = adc_start_r;

    // Counter: write first, then trigger reset, then increment
    // Trigger beats increment, so a match at FFFF never flags an overflow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= `TMC_RST_COUNT;
        end else if (wr_lo && atomic) begin
            count_r <= {hi_buf_r, hwdata[7:0]};
        end else if (wr_lo) begin
            count_r[7:0] <= hwdata[7:0];
        end else if (wr_hi && !atomic) begin
            count_r[15:8] <= hwdata[7:0];
        end else if (trig) begin
            count_r <= 16'h0000;
        end else if (inc) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // High byte buffer: written in atomic mode, loaded on low byte read
    // Loaded on the same edge as the read data, so both halves agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_buf_r <= 8'h00;
        end else if (wr_hi && atomic) begin
            hi_buf_r <= hwdata[7:0];
        end else if (rd_lo && atomic) begin
            hi_buf_r <= count_r[15:8];
        end
    end

    // Overflow only from a real wrap, never from trigger or write
    // A write to the live count in the wrap cycle wins and raises no flag
    assign ovf_set = inc && (count_r == 16'hFFFF) && !trig && !wr_lo
                     && !(wr_hi && !atomic);

    // Flag register; hardware set wins over a coincident software clear
    // Other flag bits are plain storage for software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= `TMC_RST_FLAGS;
        end else begin
            if (wr_flags) begin
                flags_r <= hwdata[7:0];
            end
            if (ovf_set) begin
                flags_r[`TMC_BIT_OVF] <= 1'b1;
            end
        end
    end

    // Interrupt gated by its enable
    // Level output; it drops when software clears the flag or the enable
    assign overflow_irq = flags_r[`TMC_BIT_OVF] && enables_r[`TMC_BIT_OVF];

endmodule

/* src/tmc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// Byte offsets, one aligned word each
`define TMC_OFF_CONTROL   12'h000
`define TMC_OFF_COUNT_LO  12'h004
`define TMC_OFF_COUNT_HI  12'h008
`define TMC_OFF_FLAGS     12'h00C
`define TMC_OFF_ENABLES   12'h010
`define TMC_OFF_CMP_PAIR  12'h014
`define TMC_OFF_CMP_MODE  12'h018

// Control field positions
`define TMC_BIT_ATOMIC    7
`define TMC_BIT_UNUSED6   6
`define TMC_BIT_PRESC_HI  5
`define TMC_BIT_PRESC_LO  4
`define TMC_BIT_OSC_EN    3
`define TMC_BIT_SYNC_BYP  2
`define TMC_BIT_CLK_SRC   1
`define TMC_BIT_COUNT_EN  0

// Overflow flag and enable position in the flag and enable registers
`define TMC_BIT_OVF       0

// Reset values
`define TMC_RST_CONTROL   8'h00
`define TMC_RST_FLAGS     8'h00
`define TMC_RST_ENABLES   8'h00
`define TMC_RST_CMP_PAIR  16'hFFFF
`define TMC_RST_CMP_MODE  4'h0
`define TMC_RST_COUNT     16'h0000

// Compare mode that issues the special event trigger
`define TMC_CMP_SPECIAL   4'hB

// Instruction cycle: Fosc/4, with hclk taken as Fosc
`define TMC_INST_DIV      2'h3

`endif

/* src/tmc_pkg.sv */
// Types shared by the timer design
package tmc_pkg;

    // Bus slave sequencing
    typedef enum logic [0:0] {
        TMC_BUS_IDLE    = 1'b0,
        TMC_BUS_RD_WAIT = 1'b1
    } tmc_bus_st_t;

endpackage

/* bench/tmc_timer_sva.sv */
// Assertions on the timer's register bus and status outputs
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_timer_sva (
    // Clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Context and status
    input wire logic        adc_enable,
    input wire logic        osc_run,
    input wire logic        osc_pins_force_input,
    input wire logic        overflow_irq,
    input wire logic        adc_start
);
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    wire         take = hsel && htrans[1] && hready;
    wire         wr_now = wr_pend_r && hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Write address kept until its data phase, where hwdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (hready) begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end
    a_osc_follows_ctrl: assert property (
        wr_now && wr_addr_r == `TMC_OFF_CONTROL |=> osc_run == $past(hwdata[3]))
        else $error("oscillator run does not follow control bit");
    a_pins_forced_in: assert property (
        wr_now && wr_addr_r == `TMC_OFF_CONTROL |=> osc_pins_force_input == $past(hwdata[3]))
        else $error("oscillator pins not forced to inputs");
    a_irq_masked: assert property (
        wr_now && wr_addr_r == `TMC_OFF_ENABLES && !hwdata[0] |=> !overflow_irq)
        else $error("interrupt passed with enable clear");
    a_bit6_zero: assert property (
        take && !hwrite && haddr[11:0] == `TMC_OFF_CONTROL
        |=> ##1 (hrdata[6] == 1'b0 && hrdata[31:8] == 24'h000000))
        else $error("unimplemented control bit read nonzero");
    a_reset_quiet: assert property (
        $rose(hresetn) |-> !osc_run && !overflow_irq && !adc_start)
        else $error("outputs active after reset");
    a_adc_gated: assert property (adc_start |-> $past(adc_enable))
        else $error("conversion start while converter disabled");
    a_adc_one_pulse: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule

bind tmc_timer tmc_timer_sva u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .adc_enable(adc_enable), .osc_run(osc_run),
    .osc_pins_force_input(osc_pins_force_input), .overflow_irq(overflow_irq),
    .adc_start(adc_start)
);

/* bench/tmc_clk_src.sv */
// Behavioural external clock source: pin or crystal, low between bursts
`timescale 1ns/100ps
module tmc_clk_src #(
    parameter int HALF = 3
) (
    // Clock and burst request
    input  wire logic       hclk,
    input  wire logic       go,
    input  wire logic [7:0] n_edges,
    input  wire logic       use_osc,
    // Status and clock lines
    output logic            busy,
    output logic            ext_clk_pin,
    output logic            osc_in_pin
);
    logic [7:0] left = 8'h00;
    int         ph   = 0;
    logic       lvl  = 1'b0;
    // Burst of n rising edges; a fall ends each one
    always @(posedge hclk) begin
        if (left != 8'h00) begin
            ph <= (ph == HALF) ? 0 : ph + 1;
            if (ph == HALF) begin
                lvl <= !lvl;
                left <= lvl ? left - 8'h01 : left;
            end
        end else if (go) begin
            left <= n_edges;
        end
    end
    // Crystal line once the oscillator runs, else the pin; the idle one stays low
    assign busy        = (left != 8'h00);
    assign ext_clk_pin = lvl && !use_osc;
    assign osc_in_pin  = lvl && use_osc;
endmodule

/* bench/tmc_timer_tb_top.sv */
// Self-checking bench for the timer block
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_timer_tb_top;
    logic        hclk;
    logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic        sleep_mode = 1'b0, adc_enable = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  n_edges = 8'h00;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, busy, ext_pin, osc_pin, osc_run, pins_in, irq, adc_start;
    int          mismatches = 0, n_tests = 0, adc_seen = 0;
    tmc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ext_clk_pin(ext_pin), .osc_in_pin(osc_pin), .sleep_mode(sleep_mode),
        .adc_enable(adc_enable), .osc_run(osc_run), .osc_pins_force_input(pins_in),
        .overflow_irq(irq), .adc_start(adc_start));
    tmc_clk_src src (.hclk(hclk), .go(go), .n_edges(n_edges), .use_osc(osc_run),
        .busy(busy), .ext_clk_pin(ext_pin), .osc_in_pin(osc_pin));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Pulses seen at the falling edge, where they are settled
    always @(negedge hclk) if (adc_start === 1'b1) adc_seen++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Ready judged before the edge; read data taken with it
    task automatic wait_rdy;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        check(rd, e);
    endtask
    // Stop, non-atomic, then load both count bytes
    task automatic load(input logic [31:0] hi, input logic [31:0] lo);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h0);
        xfer(`TMC_OFF_COUNT_HI, 1'b1, hi);
        xfer(`TMC_OFF_COUNT_LO, 1'b1, lo);
    endtask
    // Burst of edges, then room for the synchroniser to drain
    task automatic pulses(input logic [7:0] n);
        go <= 1'b1;
        n_edges <= n;
        @(posedge hclk);
        go <= 1'b0;
        @(negedge hclk);
        while (busy) @(negedge hclk);
        repeat (6) @(posedge hclk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Run takes about a thousand cycles; this limit is far past that
    initial begin
        #(100 * 20000);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`TMC_OFF_CONTROL, 32'h0);
        rdc(`TMC_OFF_FLAGS, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'hFE);
        rdc(`TMC_OFF_CONTROL, 32'hBE);
        rdc(12'h1FC, 32'h0);
        $display("test registers done");
        for (int ps = 0; ps < 4; ps++) begin
            load(32'h0, 32'h0);
            xfer(`TMC_OFF_CONTROL, 1'b1, 32'(ps * 16 + 3));
            pulses(8'd16);
            rdc(`TMC_OFF_COUNT_LO, 32'(16 >> ps));
        end
        load(32'h0, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h23);
        pulses(8'd3);
        xfer(`TMC_OFF_COUNT_HI, 1'b1, 32'h0);
        pulses(8'd1);
        rdc(`TMC_OFF_COUNT_LO, 32'h1);
        pulses(8'd3);
        xfer(`TMC_OFF_COUNT_LO, 1'b1, 32'h0);
        pulses(8'd1);
        rdc(`TMC_OFF_COUNT_LO, 32'h0);
        // Internal source for 40 core cycles, bypass bit set but ignored
        load(32'h0, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h05);
        repeat (38) @(posedge hclk);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h00);
        rdc(`TMC_OFF_COUNT_LO, 32'hA);
        $display("test prescaler done");
        load(32'h0, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h0F);
        repeat (20) @(posedge hclk);
        @(negedge hclk);
        check({30'h0, osc_run, pins_in}, 32'h3);
        @(posedge hclk);
        sleep_mode <= 1'b1;
        pulses(8'd8);
        sleep_mode <= 1'b0;
        rdc(`TMC_OFF_COUNT_LO, 32'h8);
        $display("test oscillator done");
        load(32'hFF, 32'hFE);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h03);
        pulses(8'd2);
        rdc(`TMC_OFF_COUNT_HI, 32'h0);
        rdc(`TMC_OFF_FLAGS, 32'h1);
        xfer(`TMC_OFF_ENABLES, 1'b1, 32'h1);
        @(negedge hclk);
        check({31'h0, irq}, 32'h1);
        @(posedge hclk);
        xfer(`TMC_OFF_ENABLES, 1'b1, 32'h0);
        xfer(`TMC_OFF_FLAGS, 1'b1, 32'h0);
        rdc(`TMC_OFF_FLAGS, 32'h0);
        $display("test overflow done");
        load(32'h0, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h80);
        xfer(`TMC_OFF_COUNT_HI, 1'b1, 32'hAB);
        xfer(`TMC_OFF_COUNT_LO, 1'b1, 32'hCD);
        rdc(`TMC_OFF_COUNT_LO, 32'hCD);
        rdc(`TMC_OFF_COUNT_HI, 32'hAB);
        xfer(`TMC_OFF_COUNT_HI, 1'b1, 32'h11);
        rdc(`TMC_OFF_COUNT_LO, 32'hCD);
        rdc(`TMC_OFF_COUNT_HI, 32'hAB);
        $display("test atomic done");
        load(32'h0, 32'h0);
        adc_enable <= 1'b1;
        xfer(`TMC_OFF_CMP_PAIR, 1'b1, 32'h3);
        xfer(`TMC_OFF_CMP_MODE, 1'b1, 32'hB);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h03);
        pulses(8'd4);
        rdc(`TMC_OFF_COUNT_LO, 32'h1);
        check(32'(adc_seen), 32'h1);
        rdc(`TMC_OFF_FLAGS, 32'h0);
        xfer(`TMC_OFF_CONTROL, 1'b1, 32'h02);
        pulses(8'd4);
        rdc(`TMC_OFF_COUNT_LO, 32'h1);
        $display("test trigger done");
        close_out;
    end
endmodule
